// file: shared/xbom_defs.vh
// Purpose: shared constants of the expander bus output module
// Assumes: included by bare name from every design file
// Notes:   definitions only
`ifndef XBOM_DEFS_VH
`define XBOM_DEFS_VH

// =====================================================================
// widths
`define XB_ADDR_W      6
`define XB_FC_W        4
`define XB_DATA_W      8
`define XB_ID_W        4
`define XB_TMR_W       21
`define XB_FILT_W      2
// bundle: switch(6) strobe(1) clk(1) fc(4) addr(6) data(8)
`define XB_PIN_W       26
`define XB_PIN_DATA_LO 0
`define XB_PIN_DATA_HI 7
`define XB_PIN_ADDR_LO 8
`define XB_PIN_ADDR_HI 13
`define XB_PIN_FC_LO   14
`define XB_PIN_FC_HI   17
`define XB_PIN_CLK     18
`define XB_PIN_STB_N   19
`define XB_PIN_SW_LO   20
`define XB_PIN_SW_HI   25

// =====================================================================
// function codes
`define XB_FC_WR_OUT_A 4'h0
`define XB_FC_WR_OUT_B 4'h1
`define XB_FC_WR_DEF_A 4'h2
`define XB_FC_WR_DEF_B 4'h3
`define XB_FC_WR_FLAG  4'h4
`define XB_FC_WR_HOLD  4'h5
`define XB_FC_RD_A     4'h8
`define XB_FC_RD_B     4'h9
`define XB_FC_RD_ID    4'ha

// =====================================================================
// status byte layout and reset values
`define XB_ID_LO       4
`define XB_ID_HI       7
`define XB_FLAG_BIT    0
`define XB_CTL_BIT     0
`define XB_RSV_W       3
`define XB_RSV_VAL     3'h0
`define XB_RST_BYTE    8'h00
`define XB_RST_BIT     1'h0
`define XB_ID_DEFAULT  4'ha

// =====================================================================
// timing
`define XB_FAULT_MS    10
`define XB_CLK_KHZ     200000
`define XB_FAULT_CYC   (`XB_FAULT_MS * `XB_CLK_KHZ)
`define XB_FILT_CYC    2'h3

`endif

// file: hdl/xbom_pin_filt.v
// Purpose: two-stage synchroniser and per-bit glitch filter for bus pins
// Assumes: pins are asynchronous to i_clk
// Notes:   a bit moves only after holding steady for XB_FILT_CYC+1 samples
`timescale 1ns/1ps
`default_nettype none
`include "xbom_defs.vh"

module xbom_pin_filt (
  // clock and reset
  input  wire                  i_clk,
  input  wire                  i_nrst,
  // raw pins
  input  wire [`XB_PIN_W-1:0]  i_pins,
  // filtered pins
  output wire [`XB_PIN_W-1:0]  o_pins
);

  reg [`XB_PIN_W-1:0] meta_q;
  reg [`XB_PIN_W-1:0] sync_q;

  // =====================================================================
  // synchroniser
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_q <= {`XB_PIN_W{1'b0}};
      sync_q <= {`XB_PIN_W{1'b0}};
    end else begin
      meta_q <= i_pins;
      sync_q <= meta_q;
    end
  end

  // =====================================================================
  // glitch filter
  genvar g;
  generate
    for (g = 0; g < `XB_PIN_W; g = g + 1) begin : g_bit
      reg                  out_q;
      reg [`XB_FILT_W-1:0] cnt_q;
      always @(posedge i_clk) begin
        if (!i_nrst) begin
          out_q <= 1'b0;
          cnt_q <= {`XB_FILT_W{1'b0}};
        end else if (sync_q[g] == out_q) begin
          cnt_q <= {`XB_FILT_W{1'b0}};
        end else if (cnt_q == `XB_FILT_CYC) begin
          out_q <= sync_q[g];
          cnt_q <= {`XB_FILT_W{1'b0}};
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
      assign o_pins[g] = out_q;
    end
  endgenerate

endmodule // xbom_pin_filt
`default_nettype wire

// file: hdl/xbom_fault_timer.v
// Purpose: retriggerable one-shot bus fault timer
// Assumes: i_kick is a one-cycle pulse on each bus clock edge
// Notes:   o_fault rises CYCLES clocks after the last kick
`timescale 1ns/1ps
`default_nettype none
`include "xbom_defs.vh"

module xbom_fault_timer #(
  parameter CYCLES = `XB_FAULT_CYC
) (
  // clock and reset
  input  wire i_clk,
  input  wire i_nrst,
  // retrigger
  input  wire i_kick,
  // time-out level
  output wire o_fault
);

  // cut to the counter width on purpose; the default fits in 21 bits
  localparam integer         LOAD_I = CYCLES - 1;
  localparam [`XB_TMR_W-1:0] LOAD   = LOAD_I[`XB_TMR_W-1:0];

  reg [`XB_TMR_W-1:0] cnt_q;
  reg                 fault_q;

  // =====================================================================
  // one-shot
  // after reset the timer runs, so a silent bus still faults in time
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_q   <= LOAD;
      fault_q <= 1'b0;
    end else if (i_kick) begin
      cnt_q   <= LOAD;
      fault_q <= 1'b0;
    end else if (cnt_q == {`XB_TMR_W{1'b0}}) begin
      fault_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_fault = fault_q;

endmodule // xbom_fault_timer
`default_nettype wire

// file: hdl/xbom_top.v
// Purpose: slave logic of a sixteen-channel switched output module
// Assumes: bus pins are asynchronous; transactions are taken on the
//          rising edge of the bus clock while the strobe is low
// Notes:   fault time is a parameter so benches can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "xbom_defs.vh"

module xbom_top #(
  parameter [`XB_ID_W-1:0] MODULE_ID    = `XB_ID_DEFAULT, // arbitrary value
  parameter                FAULT_CYCLES = `XB_FAULT_CYC
) (
  // clock and reset
  input  wire                  i_clk,
  input  wire                  i_nrst,
  // address switch
  input  wire [`XB_ADDR_W-1:0] i_module_address_switch,
  // expander bus, from controller
  input  wire                  i_xb_clk,
  input  wire                  i_xb_strobe_n,
  input  wire [`XB_ADDR_W-1:0] i_xb_addr,
  input  wire [`XB_FC_W-1:0]   i_xb_fc,
  input  wire [`XB_DATA_W-1:0] i_xb_data,
  // expander bus, to controller
  output wire [`XB_DATA_W-1:0] o_xb_data,
  output wire                  o_xb_data_oe_n,
  // output channels
  output wire [`XB_DATA_W-1:0] o_out_a,
  output wire [`XB_DATA_W-1:0] o_out_b,
  // indicators
  output wire                  o_fault_led,
  output wire                  o_status_flag
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_DECODE = 2'h1;
  localparam [1:0] ST_DRIVE  = 2'h2;

  // =====================================================================
  // pin conditioning
  wire [`XB_PIN_W-1:0] pins_raw;
  wire [`XB_PIN_W-1:0] pins_f;

  assign pins_raw = {i_module_address_switch, i_xb_strobe_n, i_xb_clk,
                     i_xb_fc, i_xb_addr, i_xb_data};

  xbom_pin_filt u_filt (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_pins (pins_raw),
    .o_pins (pins_f)
  );

  wire [`XB_ADDR_W-1:0] sw_f;
  wire                  stb_n_f;
  wire                  xclk_f;
  wire [`XB_FC_W-1:0]   fc_f;
  wire [`XB_ADDR_W-1:0] addr_f;
  wire [`XB_DATA_W-1:0] data_f;

  assign sw_f    = pins_f[`XB_PIN_SW_HI:`XB_PIN_SW_LO];
  assign stb_n_f = pins_f[`XB_PIN_STB_N];
  assign xclk_f  = pins_f[`XB_PIN_CLK];
  assign fc_f    = pins_f[`XB_PIN_FC_HI:`XB_PIN_FC_LO];
  assign addr_f  = pins_f[`XB_PIN_ADDR_HI:`XB_PIN_ADDR_LO];
  assign data_f  = pins_f[`XB_PIN_DATA_HI:`XB_PIN_DATA_LO];

  // =====================================================================
  // bus clock edges
  reg  xclk_q;
  wire xclk_rise;
  wire xclk_edge;

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      xclk_q <= 1'b0;
    end else begin
      xclk_q <= xclk_f;
    end
  end

  assign xclk_rise = xclk_f & ~xclk_q;
  assign xclk_edge = xclk_f ^ xclk_q;

  // =====================================================================
  // fault timer
  wire fault;

  xbom_fault_timer #(
    .CYCLES (FAULT_CYCLES)
  ) u_tmr (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_kick  (xclk_edge),
    .o_fault (fault)
  );

  // =====================================================================
  // address match and transaction capture
  wire hit;

  // six-bit switch spans addresses 0 to 63
  assign hit = xclk_rise & ~stb_n_f & (addr_f == sw_f);

  reg [1:0]            state_q;
  reg [1:0]            state_d;
  reg [`XB_FC_W-1:0]   fc_q;
  reg [`XB_DATA_W-1:0] wdata_q;

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      fc_q    <= `XB_FC_WR_OUT_A;
      wdata_q <= `XB_RST_BYTE;
    end else if (hit) begin
      fc_q    <= fc_f;
      wdata_q <= data_f;
    end
  end

  // =====================================================================
  // function code decode
  reg wr_out_a;
  reg wr_out_b;
  reg wr_def_a;
  reg wr_def_b;
  reg wr_flag;
  reg wr_hold;
  reg rd_stb;
  reg [`XB_DATA_W-1:0] rd_mux;

  wire [`XB_DATA_W-1:0] out_a_sel;
  wire [`XB_DATA_W-1:0] out_b_sel;
  wire [`XB_DATA_W-1:0] id_byte;

  always @* begin
    wr_out_a = 1'b0;
    wr_out_b = 1'b0;
    wr_def_a = 1'b0;
    wr_def_b = 1'b0;
    wr_flag  = 1'b0;
    wr_hold  = 1'b0;
    rd_stb   = 1'b0;
    rd_mux   = `XB_RST_BYTE;
    if (state_q == ST_DECODE) begin
      case (fc_q)
        `XB_FC_WR_OUT_A: wr_out_a = 1'b1;
        `XB_FC_WR_OUT_B: wr_out_b = 1'b1;
        `XB_FC_WR_DEF_A: wr_def_a = 1'b1;
        `XB_FC_WR_DEF_B: wr_def_b = 1'b1;
        `XB_FC_WR_FLAG:  wr_flag  = 1'b1;
        `XB_FC_WR_HOLD:  wr_hold  = 1'b1;
        `XB_FC_RD_A: begin
          rd_stb = 1'b1;
          rd_mux = out_a_sel;
        end
        `XB_FC_RD_B: begin
          rd_stb = 1'b1;
          rd_mux = out_b_sel;
        end
        `XB_FC_RD_ID: begin
          rd_stb = 1'b1;
          rd_mux = id_byte;
        end
        default: begin
          rd_stb = 1'b0;
        end
      endcase
    end
  end

  // =====================================================================
  // transaction sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (hit) begin
          state_d = ST_DECODE;
        end
      end
      ST_DECODE: begin
        state_d = rd_stb ? ST_DRIVE : ST_IDLE;
      end
      ST_DRIVE: begin
        // read data stands until the next bus clock rise or a time-out
        if (fault) begin
          state_d = ST_IDLE;
        end else if (hit) begin
          state_d = ST_DECODE;
        end else if (xclk_rise) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // =====================================================================
  // registers
  reg [`XB_DATA_W-1:0] out_a_q;
  reg [`XB_DATA_W-1:0] out_b_q;
  reg [`XB_DATA_W-1:0] def_a_q;
  reg [`XB_DATA_W-1:0] def_b_q;
  reg                  flag_q;
  reg                  hold_q;

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      out_a_q <= `XB_RST_BYTE;
      out_b_q <= `XB_RST_BYTE;
      def_a_q <= `XB_RST_BYTE;
      def_b_q <= `XB_RST_BYTE;
      hold_q  <= `XB_RST_BIT;
    end else begin
      if (wr_out_a) begin
        out_a_q <= wdata_q;
      end
      if (wr_out_b) begin
        out_b_q <= wdata_q;
      end
      if (wr_def_a) begin
        def_a_q <= wdata_q;
      end
      if (wr_def_b) begin
        def_b_q <= wdata_q;
      end
      if (wr_hold) begin
        hold_q <= wdata_q[`XB_CTL_BIT];
      end
    end
  end

  // flag is held until reset, a time-out or a flag write with bit 0 clear takes it away
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      flag_q <= `XB_RST_BIT;
    end else if (fault) begin
      flag_q <= `XB_RST_BIT;
    end else if (wr_flag) begin
      flag_q <= wdata_q[`XB_FLAG_BIT];
    end
  end

  assign id_byte = {MODULE_ID, `XB_RSV_VAL, flag_q};

  // =====================================================================
  // data selector
  wire use_def;

  // hold latch overrides the fallback choice during a time-out
  assign use_def   = fault & ~hold_q;
  assign out_a_sel = use_def ? def_a_q : out_a_q;
  assign out_b_sel = use_def ? def_b_q : out_b_q;

  reg [`XB_DATA_W-1:0] drv_a_q;
  reg [`XB_DATA_W-1:0] drv_b_q;

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      drv_a_q <= `XB_RST_BYTE;
      drv_b_q <= `XB_RST_BYTE;
    end else begin
      drv_a_q <= out_a_sel;
      drv_b_q <= out_b_sel;
    end
  end

  // =====================================================================
  // read data driver
  reg [`XB_DATA_W-1:0] rdata_q;
  reg                  oe_n_q;

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      rdata_q <= `XB_RST_BYTE;
      oe_n_q  <= 1'b1;
    end else if (state_q == ST_DECODE && rd_stb) begin
      rdata_q <= rd_mux;
      oe_n_q  <= 1'b0;
    end else if (state_d != ST_DRIVE) begin
      oe_n_q  <= 1'b1;
    end
  end

  // =====================================================================
  // outputs
  assign o_xb_data      = rdata_q;
  assign o_xb_data_oe_n = oe_n_q;
  assign o_out_a        = drv_a_q;
  assign o_out_b        = drv_b_q;
  assign o_fault_led    = fault;
  assign o_status_flag  = flag_q;

endmodule // xbom_top
`default_nettype wire

// file: dv/xbom_props.sv
// Purpose: port-level checks of the expander bus output module
// Assumes: bus clock halves last at least 12 i_clk cycles
// Notes:   idle_q counts cycles since the raw bus clock last moved
`timescale 1ns/1ps
`default_nettype none
`include "xbom_defs.vh"

module xbom_props #(
  parameter logic [`XB_ID_W-1:0] MODULE_ID    = `XB_ID_DEFAULT,
  parameter int                  FAULT_CYCLES = `XB_FAULT_CYC
) (
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_nrst,
  // bus side
  input wire logic [`XB_ADDR_W-1:0] i_module_address_switch,
  input wire logic                  i_xb_clk,
  input wire logic                  i_xb_strobe_n,
  input wire logic [`XB_ADDR_W-1:0] i_xb_addr,
  input wire logic [`XB_FC_W-1:0]   i_xb_fc,
  input wire logic [`XB_DATA_W-1:0] i_xb_data,
  input wire logic [`XB_DATA_W-1:0] o_xb_data,
  input wire logic                  o_xb_data_oe_n,
  // channels and indicators
  input wire logic [`XB_DATA_W-1:0] o_out_a,
  input wire logic [`XB_DATA_W-1:0] o_out_b,
  input wire logic                  o_fault_led,
  input wire logic                  o_status_flag
);
  logic        clk_q;
  logic [23:0] idle_q;
  wire         clk_chg = (i_xb_clk != clk_q);
  // writes land within 12 cycles of the raw edge
  wire         quiet   = (idle_q > 24'h0e);
  wire         mine    = !i_xb_strobe_n && i_xb_addr == i_module_address_switch;

  always @(posedge i_clk) begin
    clk_q <= i_xb_clk;
    if (!i_nrst || clk_chg) idle_q <= 24'h0;
    else if (idle_q != 24'hffffff) idle_q <= idle_q + 24'h1;
  end

  // ==========================================
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence rd_go;
    $fell(o_xb_data_oe_n);
  endsequence
  sequence kick_in_fault;
    o_fault_led && clk_chg;
  endsequence

  rst_clear_a: assert property (disable iff (1'b0)
    !i_nrst |=> !o_status_flag && !o_fault_led && o_xb_data_oe_n
    && o_out_a == 8'h00 && o_out_b == 8'h00)
    else $error("outputs not cleared by reset");
  fault_late_a: assert property (
    idle_q == FAULT_CYCLES + 12 |-> o_fault_led)
    else $error("no fault after bus clock stopped");
  // after reset the timer and idle_q start on the same edge
  fault_early_a: assert property (
    quiet && idle_q < FAULT_CYCLES |-> !o_fault_led)
    else $error("fault raised too early");
  fault_clear_a: assert property (
    kick_in_fault |-> ##[1:12] !o_fault_led)
    else $error("bus clock edge did not end fault");
  flag_drop_a: assert property (
    o_fault_led |=> !o_status_flag)
    else $error("status flag kept during fault");
  outs_steady_a: assert property (
    !o_fault_led && quiet |-> $stable(o_out_a) && $stable(o_out_b))
    else $error("outputs moved without bus traffic");
  rd_addr_a: assert property (
    rd_go |-> mine && i_xb_fc inside {`XB_FC_RD_A, `XB_FC_RD_B, `XB_FC_RD_ID})
    else $error("read answered without a matching read");
  rd_back_a: assert property (
    rd_go |-> (i_xb_fc != `XB_FC_RD_A || o_xb_data == o_out_a)
    && (i_xb_fc != `XB_FC_RD_B || o_xb_data == o_out_b))
    else $error("readback differs from outputs");
  rd_ident_a: assert property (
    rd_go and i_xb_fc == `XB_FC_RD_ID |->
    o_xb_data == {MODULE_ID, 3'h0, o_status_flag})
    else $error("identity byte wrong");
  oe_release_a: assert property (
    !o_xb_data_oe_n && clk_chg && i_xb_clk && mine |-> ##[5:12] o_xb_data_oe_n)
    else $error("read data not released");
endmodule // xbom_props

bind xbom_top xbom_props #(.MODULE_ID(MODULE_ID), .FAULT_CYCLES(FAULT_CYCLES))
  props_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_module_address_switch(i_module_address_switch), .i_xb_clk(i_xb_clk),
    .i_xb_strobe_n(i_xb_strobe_n), .i_xb_addr(i_xb_addr), .i_xb_fc(i_xb_fc),
    .i_xb_data(i_xb_data), .o_xb_data(o_xb_data),
    .o_xb_data_oe_n(o_xb_data_oe_n), .o_out_a(o_out_a), .o_out_b(o_out_b),
    .o_fault_led(o_fault_led), .o_status_flag(o_status_flag));
`default_nettype wire

// file: dv/xbom_ctl_model.sv
// Purpose: controller end of the expander bus, driving the bus pins
// Assumes: i_clk is the bench clock; pins move at its falling edge
// Notes:   bus clock stands still between transfers
`timescale 1ns/1ps
`default_nettype none
`include "xbom_defs.vh"

module xbom_ctl_model (
  // bench clock
  input  wire logic                  i_clk,
  // bus pins
  output var  logic                  o_xb_clk,
  output var  logic                  o_xb_strobe_n,
  output var  logic [`XB_ADDR_W-1:0] o_xb_addr,
  output var  logic [`XB_FC_W-1:0]   o_xb_fc,
  output var  logic [`XB_DATA_W-1:0] o_xb_data
);
  initial begin
    o_xb_clk      = 1'b0;
    o_xb_strobe_n = 1'b1;
    o_xb_addr     = 6'h0;
    o_xb_fc       = 4'h0;
    o_xb_data     = 8'h0;
  end

  // ==========================================
  // one bus period: 13 low, hi high (25 = 125 ns); short hi is a glitch
  task automatic xfer(input logic [5:0] addr, input logic [3:0] fc,
                      input logic [7:0] d, input logic sel, input int hi);
    @(negedge i_clk);
    o_xb_strobe_n = !sel;
    o_xb_addr     = addr;
    o_xb_fc       = fc;
    o_xb_data     = d;
    repeat (13) @(negedge i_clk);
    o_xb_clk = 1'b1;
    repeat (hi) @(negedge i_clk);
    o_xb_clk      = 1'b0;
    o_xb_strobe_n = 1'b1;
    // released data lines flip so a stale value cannot pass; addr and fc keep their values
    o_xb_data     = ~d;
  endtask
endmodule // xbom_ctl_model
`default_nettype wire

// file: dv/xbom_top_bench.sv
// Purpose: self-checking bench of the expander bus output module
// Assumes: fault time shortened to 200 cycles
// Notes:   bus pins come from the controller model
`timescale 1ns/1ps
`default_nettype none
`include "xbom_defs.vh"

module xbom_top_bench;
  localparam logic [5:0] ADDR = 6'h2d;
  localparam logic [3:0] ID   = 4'h6; // arbitrary value
  logic       i_clk  = 1'b0;
  logic       i_nrst = 1'b0;
  wire        xb_clk, stb_n, oe_n, led, flag;
  wire  [5:0] xb_addr;
  wire  [3:0] xb_fc;
  wire  [7:0] xb_wd, rd_data, out_a, out_b;
  int         miscompares = 0;
  int         checks_done = 0;
  int         cyc = 0;

  xbom_ctl_model ctl_u (.i_clk(i_clk), .o_xb_clk(xb_clk),
    .o_xb_strobe_n(stb_n), .o_xb_addr(xb_addr), .o_xb_fc(xb_fc),
    .o_xb_data(xb_wd));
  xbom_top #(.MODULE_ID(ID), .FAULT_CYCLES(200)) dut_u (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_module_address_switch(ADDR), .i_xb_clk(xb_clk),
    .i_xb_strobe_n(stb_n), .i_xb_addr(xb_addr), .i_xb_fc(xb_fc),
    .i_xb_data(xb_wd), .o_xb_data(rd_data), .o_xb_data_oe_n(oe_n),
    .o_out_a(out_a), .o_out_b(out_b), .o_fault_led(led),
    .o_status_flag(flag));

  initial forever #2.5 i_clk = ~i_clk;

  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] fc, input logic [7:0] d);
    ctl_u.xfer(ADDR, fc, d, 1'b1, 12);
  endtask
  task automatic rd(input logic [3:0] fc, input logic [7:0] exp);
    ctl_u.xfer(ADDR, fc, 8'h00, 1'b1, 12);
    chk("oe_n", {7'h0, oe_n}, 8'h00);
    chk("read byte", rd_data, exp);
  endtask
  task automatic outs(input logic [7:0] a, b, input logic l, f);
    chk("out_a", out_a, a);
    chk("out_b", out_b, b);
    chk("led", {7'h0, led}, {7'h0, l});
    chk("flag", {7'h0, flag}, {7'h0, f});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ==========================================
  // tests
  initial begin
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (8) @(negedge i_clk);
    outs(8'h00, 8'h00, 1'b0, 1'b0);
    $display("test reset done");
    wr(`XB_FC_WR_OUT_A, 8'h5a);
    wr(`XB_FC_WR_OUT_B, 8'hc3);
    wr(`XB_FC_WR_DEF_A, 8'h0f);
    wr(`XB_FC_WR_DEF_B, 8'hf0);
    wr(`XB_FC_WR_FLAG, 8'h01);
    outs(8'h5a, 8'hc3, 1'b0, 1'b1);
    rd(`XB_FC_RD_A, 8'h5a);
    rd(`XB_FC_RD_B, 8'hc3);
    rd(`XB_FC_RD_ID, {ID, 3'h0, 1'b1});
    $display("test config done");
    ctl_u.xfer(ADDR ^ 6'h01, `XB_FC_WR_OUT_A, 8'hff, 1'b1, 12);
    chk("oe_n off", {7'h0, oe_n}, 8'h01);
    ctl_u.xfer(ADDR, `XB_FC_WR_OUT_B, 8'hff, 1'b0, 12);
    ctl_u.xfer(ADDR, `XB_FC_WR_OUT_A, 8'hff, 1'b1, 2);
    wr(4'h6, 8'hff);
    outs(8'h5a, 8'hc3, 1'b0, 1'b1);
    $display("test refusals done");
    repeat (195) @(negedge i_clk);
    chk("led early", {7'h0, led}, 8'h00);
    repeat (20) @(negedge i_clk);
    outs(8'h0f, 8'hf0, 1'b1, 1'b0);
    rd(`XB_FC_RD_ID, {ID, 3'h0, 1'b0});
    outs(8'h5a, 8'hc3, 1'b0, 1'b0);
    wr(`XB_FC_WR_DEF_A, 8'h0f);
    wr(`XB_FC_WR_DEF_B, 8'hf0);
    wr(`XB_FC_WR_FLAG, 8'h01);
    rd(`XB_FC_RD_ID, {ID, 3'h0, 1'b1});
    $display("test fault done");
    wr(`XB_FC_WR_HOLD, 8'h01);
    repeat (220) @(negedge i_clk);
    outs(8'h5a, 8'hc3, 1'b1, 1'b0);
    $display("test hold done");
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    outs(8'h00, 8'h00, 1'b0, 1'b0);
    repeat (220) @(negedge i_clk);
    outs(8'h00, 8'h00, 1'b1, 1'b0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // xbom_top_bench
`default_nettype wire
